/* lbmc_pkg.sv */
// Package with constants, register map and state types for the LED mode control block.
`default_nettype none
package lbmc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS  = 5000;
	localparam int unsigned SS_TIME_MIN_US = 1000;
	localparam int unsigned SS_TIME_US     = 10000;
	localparam int unsigned SS_CYCLES      = SS_TIME_US * 1000 / (CLK_PERIOD_PS / 1000);
	localparam int unsigned TMR_W          = 22;

	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W         = 12;
	localparam logic [11:0] OFS_CTRL       = 12'h000;
	localparam logic [11:0] OFS_STATUS     = 12'h004;
	localparam logic [11:0] OFS_MARK       = 12'h008;
	localparam int unsigned CTRL_MARK_EN   = 0;
	localparam logic        CTRL_RESET     = 1'b1;
	localparam int unsigned ST_MODE_LSB    = 0;
	localparam int unsigned ST_STATE_LSB   = 4;
	localparam int unsigned ST_FILT_BIT    = 8;
	localparam int unsigned MK_MARK_LSB    = 0;
	localparam int unsigned MK_RULE_LSB    = 4;

	// ----------------------------------------------------------------
	// Strings, synchroniser width
	// ----------------------------------------------------------------
	localparam int unsigned NSTR           = 3;
	localparam int unsigned DROP_W         = 8;
	localparam int unsigned SYNC_W         = 6;
	localparam int unsigned STR_A          = 0;
	localparam int unsigned STR_B          = 1;
	localparam int unsigned STR_F          = 2;

	typedef enum logic [2:0] {
		ST_OFF  = 3'h1,
		ST_SOFT = 3'h2,
		ST_RUN  = 3'h4
	} lbmc_state_t;

	typedef enum logic [3:0] {
		MODE_OFF   = 4'h1,
		MODE_BL    = 4'h2,
		MODE_PREV  = 4'h4,
		MODE_FLASH = 4'h8
	} lbmc_mode_t;

endpackage
`default_nettype wire

/* lbmc_tmr_if.sv */
// Interface between the mode controller and the shared soft-start and filter timer.
`timescale 1ns/1ps
`default_nettype none
interface lbmc_tmr_if;
	logic restart;
	logic busy;
	logic done;
	modport ctl (output restart, input busy, input done);
	modport tmr (input restart, output busy, output done);
endinterface
`default_nettype wire

/* lbmc_timer.sv */
// Shared soft-start and PWM filter timer counting clock cycles.
`timescale 1ns/1ps
`default_nettype none
module lbmc_timer
	import lbmc_pkg::*;
#(
	parameter int unsigned CYCLES = SS_CYCLES
) (
	input  wire logic clk,
	input  wire logic rstn,
	lbmc_tmr_if.tmr   t
);
	localparam logic [TMR_W-1:0] LOAD = TMR_W'(CYCLES);
	localparam logic [TMR_W-1:0] ONE  = TMR_W'(1);

	logic [TMR_W-1:0] cnt_reg;
	logic [TMR_W-1:0] cnt_next;

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// A restart reloads the full count even while running, cancelling any wait.
	assign t.busy   = (cnt_reg != '0);
	assign t.done   = (cnt_reg == ONE) & ~t.restart;
	assign cnt_next = t.restart ? LOAD : (t.busy ? cnt_reg - ONE : cnt_reg); // [RULE20]

	// Count register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	// A restart always leaves the counter running on the next cycle.
	restart_len_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE20]
		t.restart |=> t.busy)
		else $error("timer not running after restart");
endmodule
`default_nettype wire

/* lbmc_top.sv */
// Mode decode, PWM filter, soft start and open-string mark-off for the LED driver.
//
// How it works
// RULE1 - Both enables low: all three strings off, go toward shutdown.
// RULE2 - Backlight enable alone: both backlight strings driven, flash string off.
// RULE3 - Both enables high: backlight strings under PWM, flash string at preview.
// RULE4 - Steady-low backlight enable: flash mode if flash enable high, else off.
// RULE5 - Enabling starts a soft-start ramp of configurable length, about 1 to 10 ms.
// RULE6 - After soft start the same timer filters PWM with the same length.
// RULE7 - Backlight low pulses shorter than the timer keep everything else running.
// RULE8 - Backlight low longer than the timer counts as steady low.
// RULE9 - Every flash enable edge restarts the timer; following change is immediate. Here only edges in run (or the enabling one) restart it, not in soft start.
// RULE10 - Host toggles flash enable through off for a fast preview-to-flash change.
// RULE11 - Slow path: backlight held low, flash only after one full timer interval.
// RULE12 - Over-voltage on the output sense stops switching.
// RULE13 - Each over-voltage event marks off strings unable to reach regulation.
// RULE14 - Marked strings do not steer the output but keep current regulation.
// RULE15 - Unmarked string with the largest drop governs output regulation.
// RULE16 - Marks persist until shutdown or the next over-voltage evaluation.
// RULE17 - A result marking off every string is ignored.
// RULE18 - Only backlight strings follow PWM; flash string is steady per mode.
// RULE19 - Passing through off cancels the running timer for a quick change.
// RULE20 - Timer is a cycle counter whose terminal count is a parameter.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lbmc_top
	import lbmc_pkg::*;
#(
	parameter int unsigned TIMER_CYCLES = SS_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic              enable_backlight,
	input  wire logic              enable_flash,
	input  wire logic              ovp_trip,
	input  wire logic [NSTR-1:0]   string_in_reg,
	input  wire logic [DROP_W-1:0] drop_a,
	input  wire logic [DROP_W-1:0] drop_b,
	input  wire logic [DROP_W-1:0] drop_f,
	output var  logic              backlight_string_a,
	output var  logic              backlight_string_b,
	output var  logic              flash_preview,
	output var  logic              flash_full,
	output var  logic              soft_start_ramp,
	output var  logic              switch_enable,
	output var  logic [NSTR-1:0]   regulation_select,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;
	logic [SYNC_W-1:0] last_reg;
	wire  [SYNC_W-1:0] pins = {string_in_reg, ovp_trip, enable_flash, enable_backlight};

	// Two flops per pin, and a third copy for edge detection.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
			sync_reg <= '0;
			last_reg <= '0;
		end else begin
			meta_reg <= pins;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	wire            bl_sync  = sync_reg[0];
	wire            fl_sync  = sync_reg[1];
	wire            ovp_sync = sync_reg[2];
	wire [NSTR-1:0] ok_sync  = sync_reg[SYNC_W-1:3];
	wire            bl_fall  = last_reg[0] & ~bl_sync;
	wire            fl_edge  = last_reg[1] ^ fl_sync;
	wire            ovp_rise = ovp_sync & ~last_reg[2];

	// ----------------------------------------------------------------
	// Shared timer
	// ----------------------------------------------------------------
	lbmc_tmr_if tmr_bus ();

	lbmc_timer #(
		.CYCLES (TIMER_CYCLES)
	) u_timer (
		.clk  (clk),
		.rstn (rstn),
		.t    (tmr_bus.tmr)
	);

	// ----------------------------------------------------------------
	// Control state and mode decode
	// ----------------------------------------------------------------
	lbmc_state_t state_reg;
	lbmc_state_t state_next;
	lbmc_mode_t  mode_reg;
	lbmc_mode_t  mode_next;
	logic        bl_hold_reg;
	logic        bl_hold_next;
	logic        ctrl_mark_en_reg;

	wire filt_bl    = bl_sync | bl_hold_reg;
	wire go_off     = ~filt_bl & ~fl_sync;
	wire in_run     = (state_reg == ST_RUN);
	wire start_up   = (state_reg == ST_OFF) & (bl_sync | fl_sync);
	wire hold_drop  = in_run & ~bl_sync & (tmr_bus.done | fl_edge);

	// Timer loads on enabling, then on backlight falls and flash enable edges.
	assign tmr_bus.restart = start_up | (in_run & (bl_fall | fl_edge)); // [RULE5] [RULE6] [RULE9]

	// Held backlight level: set wins, cleared after a full low interval or a flash edge.
	assign bl_hold_next = bl_sync | (bl_hold_reg & ~hold_drop); // [RULE7] [RULE8] [RULE19]

	// State sequence: off, soft-start ramp, then run.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_OFF: begin
				if (start_up) begin
					state_next = ST_SOFT; // [RULE5]
				end
			end
			ST_SOFT: begin
				if (go_off) begin
					state_next = ST_OFF;
				end else if (tmr_bus.done) begin
					state_next = ST_RUN; // [RULE6]
				end
			end
			ST_RUN: begin
				if (go_off) begin
					state_next = ST_OFF; // [RULE1]
				end
			end
			default: begin
				state_next = ST_OFF;
			end
		endcase
	end

	// Mode table over the filtered backlight level and the flash enable.
	always_comb begin
		if (state_next == ST_OFF) begin
			mode_next = MODE_OFF; // [RULE1]
		end else if (filt_bl && fl_sync) begin
			mode_next = MODE_PREV; // [RULE3]
		end else if (filt_bl) begin
			mode_next = MODE_BL; // [RULE2]
		end else if (fl_sync) begin
			mode_next = MODE_FLASH; // [RULE4] [RULE11]
		end else begin
			mode_next = MODE_OFF; // [RULE4]
		end
	end

	// State, mode and hold registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg   <= ST_OFF;
			mode_reg    <= MODE_OFF;
			bl_hold_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			mode_reg    <= mode_next;
			bl_hold_reg <= bl_hold_next;
		end
	end

	// ----------------------------------------------------------------
	// String drive outputs
	// ----------------------------------------------------------------
	wire bl_mode = (mode_next == MODE_BL) | (mode_next == MODE_PREV);

	// Backlight strings follow the raw PWM; the flash string only follows the mode.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			backlight_string_a <= 1'b0;
			backlight_string_b <= 1'b0;
			flash_preview      <= 1'b0;
			flash_full         <= 1'b0;
			soft_start_ramp    <= 1'b0;
			switch_enable      <= 1'b0;
		end else begin
			backlight_string_a <= bl_mode & bl_sync; // [RULE2] [RULE18]
			backlight_string_b <= bl_mode & bl_sync; // [RULE2] [RULE18]
			flash_preview      <= (mode_next == MODE_PREV); // [RULE3] [RULE18]
			flash_full         <= (mode_next == MODE_FLASH); // [RULE4]
			soft_start_ramp    <= (state_next == ST_SOFT); // [RULE5]
			switch_enable      <= (state_next != ST_OFF) & ~ovp_sync; // [RULE12]
		end
	end

	// ----------------------------------------------------------------
	// Open-string mark-off and ruling string
	// ----------------------------------------------------------------
	logic [NSTR-1:0] mark_reg;
	logic [NSTR-1:0] mark_next;
	logic [NSTR-1:0] rule_next;

	wire [NSTR-1:0] active = {flash_preview | flash_full, backlight_string_b, backlight_string_a};
	wire [NSTR-1:0] eval   = active & ~ok_sync;
	wire            all_mk = (eval == active) & (active != '0);
	wire            do_evl = ovp_rise & ctrl_mark_en_reg & (state_reg != ST_OFF);
	wire [NSTR-1:0] cand   = active & ~mark_reg;

	// Marks are re-evaluated per event, an all-marked result is dropped, off clears.
	assign mark_next = (state_next == ST_OFF) ? '0 :
	                   do_evl ? (all_mk ? '0 : eval) : mark_reg; // [RULE13] [RULE16] [RULE17]

	// Largest drop among unmarked strings picks the regulation input.
	always_comb begin
		rule_next = '0;
		if (cand[STR_A] && (!cand[STR_B] || drop_a >= drop_b)
		    && (!cand[STR_F] || drop_a >= drop_f)) begin
			rule_next[STR_A] = 1'b1; // [RULE15]
		end else if (cand[STR_B] && (!cand[STR_F] || drop_b >= drop_f)) begin
			rule_next[STR_B] = 1'b1; // [RULE15]
		end else if (cand[STR_F]) begin
			rule_next[STR_F] = 1'b1; // [RULE14]
		end
	end

	// Mark and ruling registers; string drive ignores marks so current seeking goes on.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mark_reg          <= '0;
			regulation_select <= '0;
		end else begin
			mark_reg          <= mark_next;
			regulation_select <= rule_next; // [RULE14]
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	wire        apb_setup = psel & ~penable;
	wire        apb_acc   = psel & penable;
	wire        sel_ctrl  = (paddr == OFS_CTRL);
	wire        sel_stat  = (paddr == OFS_STATUS);
	wire        sel_mark  = (paddr == OFS_MARK);
	wire        mapped    = sel_ctrl | sel_stat | sel_mark;
	wire [31:0] ctrl_word = 32'(ctrl_mark_en_reg) << CTRL_MARK_EN;
	wire [31:0] stat_word = (32'(mode_reg) << ST_MODE_LSB) | (32'(state_reg) << ST_STATE_LSB)
	                      | (32'(filt_bl) << ST_FILT_BIT);
	wire [31:0] mark_word = (32'(mark_reg) << MK_MARK_LSB)
	                      | (32'(regulation_select) << MK_RULE_LSB);
	wire [31:0] rd_mux    = sel_ctrl ? ctrl_word : sel_stat ? stat_word :
	                        sel_mark ? mark_word : 32'h0000_0000;

	// Zero wait states; unmapped addresses answer with an error.
	assign pready  = 1'b1;
	assign pslverr = apb_acc & ~mapped;

	// Read data captured in the setup phase, control written in the access phase.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata           <= 32'h0000_0000;
			ctrl_mark_en_reg <= CTRL_RESET;
		end else begin
			if (apb_setup && !pwrite) begin
				prdata <= rd_mux;
			end
			if (apb_acc && pwrite && sel_ctrl) begin
				ctrl_mark_en_reg <= pwdata[CTRL_MARK_EN];
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	off_all_dark_a: assert property ($past(mode_next) == MODE_OFF |-> // [RULE1]
		!backlight_string_a && !backlight_string_b && !flash_preview && !flash_full)
		else $error("string lit in off mode");
	bl_no_flash_a: assert property (mode_reg == MODE_BL |-> !flash_preview && !flash_full) // [RULE2]
		else $error("flash string lit in backlight mode");
	preview_level_a: assert property (mode_reg == MODE_PREV |-> flash_preview && !flash_full) // [RULE3]
		else $error("preview mode without preview drive");
	flash_only_a: assert property (mode_reg == MODE_FLASH |-> // [RULE4]
		flash_full && !backlight_string_a && !backlight_string_b)
		else $error("flash mode drive wrong");
	soft_to_run_a: assert property (state_reg == ST_SOFT && tmr_bus.done && !go_off |=> // [RULE6]
		state_reg == ST_RUN && !soft_start_ramp)
		else $error("soft start did not end on timer done");
	short_low_a: assert property (in_run && bl_fall && !fl_edge |=> filt_bl [*2]) // [RULE7]
		else $error("short backlight low not filtered");
	flash_edge_a: assert property (in_run && fl_edge && !bl_sync |=> !bl_hold_reg) // [RULE9]
		else $error("flash enable edge did not cancel hold");
	ovp_no_switch_a: assert property (ovp_sync |=> !switch_enable) // [RULE12]
		else $error("switching during over-voltage");
	never_all_mark_a: assert property (do_evl |=> // [RULE17]
		$past(active) == '0 || (mark_reg & $past(active)) != $past(active))
		else $error("every lit string marked off");
	mark_stable_a: assert property (state_reg != ST_OFF && state_next != ST_OFF && !do_evl // [RULE16]
		|=> $stable(mark_reg))
		else $error("mark flags changed without event");
	ruling_free_a: assert property ((regulation_select & $past(mark_reg)) == '0) // [RULE14]
		else $error("marked string governs regulation");
endmodule
`default_nettype wire

/* lbmc_host_model.sv */
// Host model that drives the two enable pins, with optional PWM on the backlight enable.
`timescale 1ns/1ps
`default_nettype none
module lbmc_host_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       bl_cmd,
	input  wire logic       fl_cmd,
	input  wire logic       pwm_on,
	input  wire logic [7:0] pwm_low,
	input  wire logic [7:0] pwm_period,
	output var  logic       enable_backlight,
	output var  logic       enable_flash
);
	logic [7:0] cnt_reg;

	// Pins change only after a rising edge; PWM holds the pin low for pwm_low cycles of each period.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			enable_backlight <= 1'b0;
			enable_flash     <= 1'b0;
			cnt_reg          <= 8'h00;
		end else begin
			enable_flash <= fl_cmd;
			if (pwm_on) begin
				cnt_reg          <= (cnt_reg == pwm_period - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
				enable_backlight <= (cnt_reg >= pwm_low);
			end else begin
				enable_backlight <= bl_cmd;
				cnt_reg          <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

/* tb_led_driver_mode_control.sv */
// Self-checking testbench for the LED mode control block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(gv, ev) begin num_checks++; if ((gv) !== (ev)) begin err_count++; \
	$display("wrong value at %0t: got %h exp %h", $time, (gv), (ev)); end end
module tb_led_driver_mode_control;
	import lbmc_pkg::*;
	localparam int unsigned TC = 20;
	typedef struct packed {logic bl; logic fl; logic [3:0] outs; logic [3:0] mode;} lbmc_row_t;
	logic clk = 1'b0, rstn = 1'b0, bl_cmd = 1'b0, fl_cmd = 1'b0, pwm_on = 1'b0, ovp_trip = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pslverr, pready, en_bl, en_fl;
	logic backlight_string_a, backlight_string_b, flash_preview, flash_full, ramp, sw_en;
	logic [NSTR-1:0] string_in = 3'h7, reg_sel;
	logic [DROP_W-1:0] drop_a = 8'h10, drop_b = 8'h50, drop_f = 8'h20;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic e, seen_low, prev_ok;
	int err_count = 0, num_checks = 0, cyc = 0;
	lbmc_row_t rows [5];
	wire [3:0] lit = {backlight_string_a, backlight_string_b, flash_preview, flash_full};

	initial begin
		forever #2.5 clk = ~clk;
	end

	lbmc_host_model host_u (.clk(clk), .rstn(rstn), .bl_cmd(bl_cmd), .fl_cmd(fl_cmd),
		.pwm_on(pwm_on), .pwm_low(8'h08), .pwm_period(8'h10),
		.enable_backlight(en_bl), .enable_flash(en_fl));

	lbmc_top #(.TIMER_CYCLES(TC)) dut_u (.clk(clk), .rstn(rstn), .enable_backlight(en_bl),
		.enable_flash(en_fl), .ovp_trip(ovp_trip), .string_in_reg(string_in), .drop_a(drop_a),
		.drop_b(drop_b), .drop_f(drop_f), .backlight_string_a(backlight_string_a),
		.backlight_string_b(backlight_string_b), .flash_preview(flash_preview),
		.flash_full(flash_full), .soft_start_ramp(ramp), .switch_enable(sw_en),
		.regulation_select(reg_sel), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Waits n rising edges, then lets their updates settle.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One APB transfer: setup, access held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	// Sets both enable commands at a rising edge.
	task automatic pins(input logic b, input logic f);
		@(posedge clk);
		bl_cmd <= b;
		fl_cmd <= f;
	endtask

	// Single overvoltage pulse with the given regulation status on the strings.
	task automatic ovp_pulse(input logic [2:0] s);
		@(posedge clk);
		string_in <= s;
		repeat (4) @(posedge clk);
		ovp_trip <= 1'b1;
		tick(6);
		`CHK(sw_en, 1'b0)
		@(posedge clk);
		ovp_trip <= 1'b0;
		tick(8);
	endtask

	// Ends a hung run.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rows[0] = '{1'b0, 1'b0, 4'b0000, MODE_OFF};
		rows[1] = '{1'b1, 1'b0, 4'b1100, MODE_BL};
		rows[2] = '{1'b1, 1'b1, 4'b1110, MODE_PREV};
		rows[3] = '{1'b0, 1'b1, 4'b0001, MODE_FLASH};
		rows[4] = '{1'b0, 1'b0, 4'b0000, MODE_OFF};
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		tick(2);
		pins(1'b1, 1'b0);
		tick(6);
		`CHK(ramp, 1'b1)
		tick(TC + 10);
		`CHK(ramp, 1'b0)
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK(r[6:4], ST_RUN)
		`CHK(sw_en, 1'b1)
		pins(1'b0, 1'b0);
		tick(TC + 10);
		$display("test soft start done");
		foreach (rows[i]) begin
			pins(rows[i].bl, rows[i].fl);
			tick(3 * TC);
			`CHK(lit, rows[i].outs)
			apb(1'b0, OFS_STATUS, 32'h0);
			`CHK(r[3:0], rows[i].mode)
		end
		`CHK(sw_en, 1'b0)
		$display("test mode table done");
		pins(1'b1, 1'b1);
		tick(3 * TC);
		@(posedge clk);
		pwm_on <= 1'b1;
		seen_low = 1'b0;
		prev_ok = 1'b1;
		repeat (64) begin
			tick(1);
			seen_low = seen_low | ~backlight_string_a;
			prev_ok = prev_ok & flash_preview & ~flash_full;
		end
		`CHK(prev_ok, 1'b1)
		`CHK(seen_low, 1'b1)
		@(posedge clk);
		pwm_on <= 1'b0;
		tick(3 * TC);
		$display("test pwm done");
		pins(1'b0, 1'b1);
		tick(TC / 2);
		`CHK(flash_full, 1'b0)
		tick(2 * TC);
		`CHK(flash_full, 1'b1)
		$display("test slow path done");
		pins(1'b1, 1'b1);
		tick(3 * TC);
		`CHK(flash_preview, 1'b1)
		pins(1'b0, 1'b0);
		tick(3);
		pins(1'b0, 1'b1);
		tick(10);
		`CHK(flash_full, 1'b1)
		$display("test fast path done");
		pins(1'b0, 1'b0);
		tick(3 * TC);
		pins(1'b1, 1'b0);
		tick(3 * TC);
		`CHK(reg_sel, 3'b010)
		ovp_pulse(3'b001);
		apb(1'b0, OFS_MARK, 32'h0);
		`CHK(r[2:0], 3'b010)
		`CHK(reg_sel, 3'b001)
		`CHK(backlight_string_b, 1'b1)
		ovp_pulse(3'b000);
		apb(1'b0, OFS_MARK, 32'h0);
		`CHK(r[2:0], 3'b000)
		ovp_pulse(3'b001);
		pins(1'b0, 1'b0);
		tick(3 * TC);
		apb(1'b0, OFS_MARK, 32'h0);
		`CHK(r[2:0], 3'b000)
		$display("test mark-off done");
		apb(1'b0, 12'h00C, 32'h0);
		`CHK({e, r}, {1'b1, 32'h0000_0000})
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK(r[0], 1'b0)
		`CHK(e, 1'b0)
		`CHK(pready, 1'b1)
		pins(1'b1, 1'b0);
		tick(3 * TC);
		ovp_pulse(3'b001);
		apb(1'b0, OFS_MARK, 32'h0);
		`CHK(r[2:0], 3'b000)
		@(posedge clk);
		rstn <= 1'b0;
		tick(2);
		`CHK(lit, 4'h0)
		pins(1'b0, 1'b0);
		rstn <= 1'b1;
		apb(1'b0, OFS_CTRL, 32'h0);
		`CHK(r[0], CTRL_RESET)
		$display("test registers and reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
